/* pkg/ledfh_pkg.sv */
// constants, register map and carrier types of the led driver fault handler
package ledfh_pkg;

	localparam int NUM_CH          = 10;
	localparam int NUM_FAULTS      = 12;
	localparam int ADDR_W          = 8;
	localparam int DATA_W          = 8;
	localparam int SEL_W           = 4;

	// register offsets
	localparam logic [7:0] ADDR_FAULT_LO   = 8'h38;
	localparam logic [7:0] ADDR_FAULT_HI   = 8'h39;
	localparam logic [7:0] ADDR_REGLAT_LO  = 8'h3A;
	localparam logic [7:0] ADDR_REGLAT_HI  = 8'h3B;
	localparam logic [7:0] ADDR_SHORT_LO   = 8'h3C;
	localparam logic [7:0] ADDR_SHORT_HI   = 8'h3D;
	localparam logic [7:0] ADDR_CH_EN_LO   = 8'h40;
	localparam logic [7:0] ADDR_CH_EN_HI   = 8'h41;
	localparam logic [7:0] ADDR_CONFIG     = 8'h42;
	localparam logic [7:0] ADDR_MON_SEL    = 8'h43;
	localparam logic [7:0] ADDR_CH_OVP_LO  = 8'h44;
	localparam logic [7:0] ADDR_CH_OVP_HI  = 8'h45;

	// fault numbers, one-based as printed
	localparam int F_IN_OC      = 1;
	localparam int F_TEMP_WARN  = 3;
	localparam int F_TSD        = 4;
	localparam int F_OVP        = 8;
	localparam int F_PIN_SHORT  = 11;

	// config field positions
	localparam int CFG_DERATE_BIT  = 0;
	localparam int CFG_LATCH_LO    = 1;
	localparam int CFG_LATCH_W     = 4;

	// reset values
	localparam logic [NUM_CH-1:0] CH_EN_RST   = 10'h3FF;
	localparam logic [7:0]        CONFIG_RST  = 8'h00;
	localparam logic [7:0]        MON_SEL_RST = 8'h00;

	// thermal figures in degrees c, for reference of the comparator levels
	localparam int TSD_DEG_C          = 170;
	localparam int TSD_HYST_DEG_C     = 20;
	localparam int DERATE_MARGIN_DEG  = 20;

	// register access strobe group
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ledfh_reg_req_t;

	// analog comparator and event inputs
	typedef struct packed {
		logic              in_overcurrent;
		logic              ovp_trip;
		logic              tsd_hot;
		logic              tsd_cool;
		logic              derate_zone;
		logic [NUM_CH-1:0] pin_low;
		logic [NUM_CH-1:0] pin_high;
		logic [NUM_CH-1:0] in_reg;
		logic [NUM_FAULTS-1:0] ext_fault;
	} ledfh_sense_t;

	// power stage controls
	typedef struct packed {
		logic              disconnect_on;
		logic              boost_on;
		logic              leds_on;
		logic              soft_start_go;
		logic              derate_on;
		logic              pullup_on;
		logic              retest_on;
		logic [NUM_CH-1:0] ch_regulate;
		logic [NUM_CH-1:0] boost_raise;
	} ledfh_ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CHECK   = 3'b001,
		ST_RUN     = 3'b011,
		ST_RETEST  = 3'b010,
		ST_OFF     = 3'b110
	} ledfh_state_t;

	// selects bit idx of a 16-bit status vector; a 4-bit idx reaches every bit, so none is out of range
	function automatic logic ledfh_pick(input logic [15:0] v, input logic [SEL_W-1:0] idx);
		ledfh_pick = v[idx];
	endfunction

endpackage

/* rtl/ledfh_monitor.sv */
// open-drain monitor output driver with programmable status select
`timescale 1ns/1ps
module ledfh_monitor (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic [15:0]              status,
	input  wire logic [ledfh_pkg::SEL_W-1:0] sel,
	output logic                          pin_o,
	output logic                          pin_oe
);
	import ledfh_pkg::*;

	logic active_reg;

	// registered so the pin never glitches while select changes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			active_reg <= 1'b0;
		else
			active_reg <= ledfh_pick(status, sel);
	end

	// pull low while asserted, release otherwise
	assign pin_o  = 1'b0;
	assign pin_oe = active_reg;

	chk_drive_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
		ledfh_pick(status, sel) |=> pin_oe) else $error("monitor pin not driven low");

endmodule

/* rtl/ledfh_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module ledfh_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

/* rtl/ledfh_top.sv */
// fault supervision core of the multi-channel led driver
`timescale 1ns/1ps
module ledfh_top (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic                     enable_pin,
	input  wire ledfh_pkg::ledfh_reg_req_t reg_req,
	output logic [ledfh_pkg::DATA_W-1:0]  reg_rdata,
	input  wire ledfh_pkg::ledfh_sense_t  sense,
	output ledfh_pkg::ledfh_ctrl_t        ctrl,
	output logic                          fault_flag_n_o,
	output logic                          fault_flag_n_oe,
	output logic                          monitor_out_a_o,
	output logic                          monitor_out_a_oe,
	output logic                          monitor_out_b_o,
	output logic                          monitor_out_b_oe
);
	import ledfh_pkg::*;

	localparam int SW = $bits(ledfh_sense_t);

	ledfh_sense_t           s;
	logic                   en_sync;
	ledfh_state_t           state_reg;
	ledfh_state_t           state_next;
	logic [NUM_FAULTS-1:0]  fault_reg;
	logic [NUM_FAULTS-1:0]  fault_raw;
	logic [NUM_CH-1:0]      ch_en_reg;
	logic [NUM_CH-1:0]      in_use_reg;
	logic [NUM_CH-1:0]      dropped_reg;
	logic [NUM_CH-1:0]      short_reg;
	logic [NUM_CH-1:0]      ch_ovp_reg;
	logic [7:0]             config_reg;
	logic [7:0]             mon_sel_reg;
	logic                   en_prev_reg;
	logic                   ovp_prev_reg;
	logic                   first_done_reg;
	logic                   tsd_active_reg;
	logic                   oc_latched_reg;
	logic [NUM_CH-1:0]      active_ch;
	logic [NUM_CH-1:0]      retest_set;
	logic                   en_rise;
	logic                   en_fall;
	logic [15:0]            mon_status;

	// comparator and pin levels come from the analog side, so synchronise
	ledfh_sync #(.W(SW)) u_sense_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.d       (sense),
		.q       (s)
	);

	ledfh_sync #(.W(1)) u_en_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.d       (enable_pin),
		.q       (en_sync)
	);

	assign en_rise = en_sync & ~en_prev_reg;
	assign en_fall = ~en_sync & en_prev_reg;

	// channels taking part in regulation
	assign active_ch  = ch_en_reg & in_use_reg & ~dropped_reg;
	assign retest_set = active_ch & ~s.in_reg;

	// raw fault conditions, fault n sits at bit n-1
	always_comb
	begin
		fault_raw                  = s.ext_fault;
		fault_raw[F_IN_OC-1]       = s.in_overcurrent;
		fault_raw[F_TEMP_WARN-1]   = s.derate_zone;
		fault_raw[F_TSD-1]         = tsd_active_reg;
		fault_raw[F_OVP-1]         = s.ovp_trip;
		fault_raw[F_PIN_SHORT-1]   = (state_reg == ST_RETEST) && |(retest_set & s.pin_low);
	end

	// enable and overvoltage edge tracking; a trip that stands for several cycles
	// must start one retest only, since sense data during retest is not meaningful
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			en_prev_reg  <= 1'b0;
			ovp_prev_reg <= 1'b0;
		end
		else
		begin
			en_prev_reg  <= en_sync;
			ovp_prev_reg <= s.ovp_trip;
		end
	end

	// thermal shutdown with hysteresis: leave only at the cool comparator
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			tsd_active_reg <= 1'b0;
		else if (s.tsd_hot)
			tsd_active_reg <= 1'b1;
		else if (s.tsd_cool)
			tsd_active_reg <= 1'b0;
	end

	// input overcurrent latch, released only by an enable toggle
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			oc_latched_reg <= 1'b0;
		else if (s.in_overcurrent)
			oc_latched_reg <= 1'b1;
		else if (en_fall)
			oc_latched_reg <= 1'b0;
	end

	// fault flags: latching ones hold until enable drops, auto ones follow the cause
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			fault_reg <= '0;
		else
		begin
			for (int i = 0; i < NUM_FAULTS; i++)
			begin
				logic latching;
				latching = (i == F_IN_OC-1) || (i == F_PIN_SHORT-1) ||
				           (i >= F_TSD-1 && i < F_TSD-1+CFG_LATCH_W &&
				            config_reg[CFG_LATCH_LO + i - (F_TSD-1)]);
				if (fault_raw[i])
					fault_reg[i] <= 1'b1; // set wins
				else if (latching ? en_fall : 1'b1)
					fault_reg[i] <= 1'b0;
			end
			// an open channel cleared by the retest also clears the overvoltage flag
			if (state_reg == ST_RETEST && !(|(retest_set & s.pin_low)) && !s.ovp_trip)
				fault_reg[F_OVP-1] <= 1'b0;
		end
	end

	// top-level sequence
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (en_rise)
					state_next = first_done_reg ? ST_RUN : ST_CHECK;
			ST_CHECK:
				if (!en_sync)
					state_next = ST_IDLE;
				else if (!(|s.pin_low))
					state_next = ST_RUN;
			ST_RUN:
				if (!en_sync)
					state_next = ST_IDLE;
				else if (s.in_overcurrent)
					state_next = ST_OFF;
				else if (s.ovp_trip && !ovp_prev_reg)
					state_next = ST_RETEST;
			ST_RETEST:
				if (|(retest_set & s.pin_low))
					state_next = ST_OFF;
				else
					state_next = ST_RUN;
			ST_OFF:
				if (!en_sync)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// startup pin classification, done once
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			first_done_reg <= 1'b0;
			in_use_reg     <= '0;
		end
		else if (state_reg == ST_CHECK && state_next == ST_RUN)
		begin
			first_done_reg <= 1'b1;
			in_use_reg     <= s.pin_high;
		end
	end

	// retest outcome per channel
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dropped_reg <= '0;
			short_reg   <= '0;
			ch_ovp_reg  <= '0;
		end
		else if (state_reg == ST_RETEST)
		begin
			short_reg   <= short_reg | (retest_set & s.pin_low);
			dropped_reg <= dropped_reg | (retest_set & ~s.pin_low);
			ch_ovp_reg  <= ch_ovp_reg | retest_set;
		end
		else
			ch_ovp_reg  <= ch_ovp_reg & ch_en_reg; // disabled reads 0
	end

	// register writes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ch_en_reg   <= CH_EN_RST;
			config_reg  <= CONFIG_RST; // derating off by default
			mon_sel_reg <= MON_SEL_RST;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				ADDR_CH_EN_LO: ch_en_reg[7:0] <= reg_req.wdata;
				ADDR_CH_EN_HI: ch_en_reg[NUM_CH-1:8] <= reg_req.wdata[NUM_CH-9:0];
				ADDR_CONFIG:   config_reg <= reg_req.wdata;
				ADDR_MON_SEL:  mon_sel_reg <= reg_req.wdata;
				default:       ;
			endcase
		end
	end

	// register reads, unmapped reads as zero
	always_comb
	begin
		case (reg_req.addr)
			ADDR_FAULT_LO:  reg_rdata = fault_reg[7:0];
			ADDR_FAULT_HI:  reg_rdata = {4'h0, fault_reg[NUM_FAULTS-1:8]};
			ADDR_REGLAT_LO: reg_rdata = dropped_reg[7:0];
			ADDR_REGLAT_HI: reg_rdata = {6'h00, dropped_reg[NUM_CH-1:8]};
			ADDR_SHORT_LO:  reg_rdata = short_reg[7:0];
			ADDR_SHORT_HI:  reg_rdata = {6'h00, short_reg[NUM_CH-1:8]};
			ADDR_CH_EN_LO:  reg_rdata = ch_en_reg[7:0];
			ADDR_CH_EN_HI:  reg_rdata = {6'h00, ch_en_reg[NUM_CH-1:8]};
			ADDR_CONFIG:    reg_rdata = config_reg;
			ADDR_MON_SEL:   reg_rdata = mon_sel_reg;
			ADDR_CH_OVP_LO: reg_rdata = ch_ovp_reg[7:0];
			ADDR_CH_OVP_HI: reg_rdata = {6'h00, ch_ovp_reg[NUM_CH-1:8]};
			default:        reg_rdata = 8'h00;
		endcase
	end

	// power stage controls; stuck shutdown states keep boost, leds and channel regulation off
	always_comb
	begin
		ctrl               = '0;
		ctrl.disconnect_on = en_sync && !oc_latched_reg;
		ctrl.pullup_on     = (state_reg == ST_CHECK) || (state_reg == ST_RETEST);
		ctrl.retest_on     = (state_reg == ST_RETEST);
		ctrl.soft_start_go = (state_reg == ST_RUN);
		ctrl.boost_on      = (state_reg == ST_RUN) && !tsd_active_reg && !oc_latched_reg;
		ctrl.leds_on       = ctrl.boost_on;
		ctrl.derate_on     = config_reg[CFG_DERATE_BIT] && s.derate_zone;
		ctrl.ch_regulate   = ctrl.leds_on ? active_ch : '0;
		ctrl.boost_raise   = ctrl.ch_regulate & ~s.in_reg;
	end

	// flag pin pulled low while any flag-raising fault stands
	assign fault_flag_n_o  = 1'b0;
	assign fault_flag_n_oe = fault_reg[F_IN_OC-1] | fault_reg[F_TSD-1] | fault_reg[F_OVP-1] |
	                         fault_reg[F_PIN_SHORT-1];

	// monitor choices: faults then run state
	assign mon_status = {3'h0, (state_reg == ST_RUN), fault_reg};

	ledfh_monitor u_mon_a (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.status  (mon_status),
		.sel     (mon_sel_reg[3:0]),
		.pin_o   (monitor_out_a_o),
		.pin_oe  (monitor_out_a_oe)
	);

	ledfh_monitor u_mon_b (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.status  (mon_status),
		.sel     (mon_sel_reg[7:4]),
		.pin_o   (monitor_out_b_o),
		.pin_oe  (monitor_out_b_oe)
	);

	chk_tsd_kills_boost: assert property (@(posedge ref_clk) disable iff (!rstn)
		s.tsd_hot |=> !ctrl.boost_on && !ctrl.leds_on) else $error("boost on during thermal shutdown");
	chk_tsd_hold_hyst: assert property (@(posedge ref_clk) disable iff (!rstn)
		tsd_active_reg && !s.tsd_cool |=> tsd_active_reg) else $error("thermal shutdown left early");
	chk_short_holds_start: assert property (@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_CHECK && |s.pin_low |=> state_reg != ST_RUN) else $error("soft start with short");
	chk_raise_only_active: assert property (@(posedge ref_clk) disable iff (!rstn)
		(ctrl.boost_raise & ~active_ch) == '0) else $error("inactive channel raises boost");
	chk_retest_short_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_RETEST && |(retest_set & s.pin_low) |=> state_reg == ST_OFF && fault_reg[F_PIN_SHORT-1])
		else $error("retest short not handled");
	chk_retest_open_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_RETEST && !(|(retest_set & s.pin_low)) |=> (dropped_reg & $past(retest_set)) == $past(retest_set))
		else $error("open channel not dropped");
	chk_oc_latch_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		s.in_overcurrent |=> !ctrl.disconnect_on && fault_flag_n_oe) else $error("overcurrent not latched");
	chk_derate_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
		!config_reg[CFG_DERATE_BIT] |-> !ctrl.derate_on) else $error("derating while disabled");
	chk_latch_fault_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		fault_reg[F_PIN_SHORT-1] && !en_fall |=> fault_reg[F_PIN_SHORT-1]) else $error("latched fault lost");

endmodule

/* verif/ledfh_pins_model.sv */
// channel pin comparator model: grounded, unused and open strings as seen by the sense comparators
`timescale 1ns/1ps
module ledfh_pins_model (
	input  wire logic [ledfh_pkg::NUM_CH-1:0] ch_regulate,
	input  wire logic                         pullup_on,
	input  wire logic [ledfh_pkg::NUM_CH-1:0] ch_used,
	input  wire logic [ledfh_pkg::NUM_CH-1:0] ch_short,
	input  wire logic [ledfh_pkg::NUM_CH-1:0] ch_open,
	output logic      [ledfh_pkg::NUM_CH-1:0] pin_low,
	output logic      [ledfh_pkg::NUM_CH-1:0] pin_high,
	output logic      [ledfh_pkg::NUM_CH-1:0] in_reg
);
	import ledfh_pkg::*;

	// a grounded pin stays under the low threshold whatever the pull-up does
	assign pin_low  = ch_short;
	// a terminated unused pin sits between thresholds; only a populated pin rises, and only while pulled up
	assign pin_high = {NUM_CH{pullup_on}} & ch_used & ~ch_short;
	// no string current on an open or grounded pin, so it never reaches regulation
	assign in_reg   = ch_regulate & ch_used & ~ch_short & ~ch_open;
endmodule

/* verif/ledfh_top_tb.sv */
// self-checking bench of the led driver fault handler
`timescale 1ns/1ps
module ledfh_top_tb;
	import ledfh_pkg::*;

	typedef struct {
		logic [7:0] addr;
		logic [7:0] exp;
	} ledfh_row_t;

	logic              ref_clk;
	logic              rstn;
	logic              enable_pin;
	ledfh_reg_req_t    reg_req;
	logic [DATA_W-1:0] reg_rdata;
	ledfh_sense_t      sense;
	ledfh_ctrl_t       ctrl;
	logic              fault_flag_n_o;
	logic              fault_flag_n_oe;
	logic              mon_a_o;
	logic              mon_a_oe;
	logic              mon_b_o;
	logic              mon_b_oe;
	logic              mon_a_lvl;
	logic              mon_b_lvl;
	logic              oc;
	logic              output_overvoltage_fault;
	logic              hot;
	logic              cool;
	logic              dzone;
	logic [NUM_CH-1:0] used;
	logic [NUM_CH-1:0] shorted;
	logic [NUM_CH-1:0] opened;
	logic [NUM_CH-1:0] p_low;
	logic [NUM_CH-1:0] p_high;
	logic [NUM_CH-1:0] p_reg;
	int                n_fail;
	int                compares;
	int                cycles;
	ledfh_row_t        rows [10];

	ledfh_top u_ledfh_top (
		.ref_clk         (ref_clk),
		.rstn            (rstn),
		.enable_pin      (enable_pin),
		.reg_req         (reg_req),
		.reg_rdata       (reg_rdata),
		.sense           (sense),
		.ctrl            (ctrl),
		.fault_flag_n_o  (fault_flag_n_o),
		.fault_flag_n_oe (fault_flag_n_oe),
		.monitor_out_a_o (mon_a_o),
		.monitor_out_a_oe(mon_a_oe),
		.monitor_out_b_o (mon_b_o),
		.monitor_out_b_oe(mon_b_oe)
	);

	ledfh_pins_model u_ledfh_pins_model (
		.ch_regulate(ctrl.ch_regulate),
		.pullup_on  (ctrl.pullup_on),
		.ch_used    (used),
		.ch_short   (shorted),
		.ch_open    (opened),
		.pin_low    (p_low),
		.pin_high   (p_high),
		.in_reg     (p_reg)
	);

	// external pull-ups on the open-drain monitor pins
	assign mon_a_lvl = mon_a_oe ? mon_a_o : 1'b1;
	assign mon_b_lvl = mon_b_oe ? mon_b_o : 1'b1;

	// sense bundle; other fault sources stay quiet in this bench
	always_comb
	begin
		sense = '0;
		sense.in_overcurrent = oc;
		sense.ovp_trip = output_overvoltage_fault;
		sense.tsd_hot = hot;
		sense.tsd_cool = cool;
		sense.derate_zone = dzone;
		sense.pin_low = p_low;
		sense.pin_high = p_high;
		sense.in_reg = p_reg;
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// hang guard, well above the few hundred cycles the sequence needs
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// ends on the falling edge so outputs have settled when compared
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_req.wr <= 1'b1;
		reg_req.addr <= a;
		reg_req.wdata <= d;
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask

	// read data is combinational, taken mid-cycle while the address holds
	task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		@(posedge ref_clk);
		reg_req.rd <= 1'b1;
		reg_req.addr <= a;
		@(negedge ref_clk);
		d = reg_rdata;
		chk_byte($sformatf("register %h", a), exp, d);
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
	endtask

	// trip pulse long enough to pass the input synchroniser
	task automatic ovp_pulse();
		@(posedge ref_clk);
		output_overvoltage_fault <= 1'b1;
		repeat (4) @(posedge ref_clk);
		output_overvoltage_fault <= 1'b0;
	endtask

	initial
	begin
		rstn = 1'b0;
		enable_pin = 1'b0;
		reg_req = '0;
		{oc, output_overvoltage_fault, hot, cool, dzone} = 5'h00;
		used = 10'h3DF;
		shorted = 10'h004;
		opened = 10'h008;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		rows = '{'{ADDR_FAULT_LO, 8'h00}, '{ADDR_FAULT_HI, 8'h00}, '{ADDR_REGLAT_LO, 8'h00},
			'{ADDR_REGLAT_HI, 8'h00}, '{ADDR_SHORT_LO, 8'h00}, '{ADDR_CH_EN_LO, 8'hFF},
			'{ADDR_CH_EN_HI, 8'h03}, '{ADDR_CONFIG, 8'h00}, '{ADDR_MON_SEL, 8'h00}, '{8'h50, 8'h00}};
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		// reset values, unmapped place last
		foreach (rows[i])
			check_reg(rows[i].addr, rows[i].exp);
		reg_write(ADDR_FAULT_LO, 8'hFF);
		check_reg(ADDR_FAULT_LO, 8'h00);
		reg_write(ADDR_CH_EN_LO, 8'h7F);
		reg_write(ADDR_MON_SEL, 8'hC2);
		// first enable with channel 2 grounded
		@(posedge ref_clk);
		enable_pin <= 1'b1;
		cyc(10);
		chk_bit("pullup", 1'b1, ctrl.pullup_on);
		chk_bit("soft start held", 1'b0, ctrl.soft_start_go);
		@(posedge ref_clk);
		shorted <= '0;
		cyc(10);
		chk_bit("soft start", 1'b1, ctrl.soft_start_go);
		chk_byte("regulate", 8'h5F, ctrl.ch_regulate[7:0]);
		chk_byte("raise", 8'h08, ctrl.boost_raise[7:0]);
		chk_bit("mon b running", 1'b0, mon_b_lvl);
		chk_bit("mon a idle", 1'b1, mon_a_lvl);
		// derating only once enabled
		@(posedge ref_clk);
		dzone <= 1'b1;
		cyc(8);
		chk_bit("derate default", 1'b0, ctrl.derate_on);
		chk_bit("mon a warn", 1'b0, mon_a_lvl);
		reg_write(ADDR_CONFIG, 8'h01);
		cyc(4);
		chk_bit("derate", 1'b1, ctrl.derate_on);
		// thermal shutdown and hysteresis
		@(posedge ref_clk);
		hot <= 1'b1;
		cyc(8);
		chk_bit("boost hot", 1'b0, ctrl.boost_on);
		chk_bit("leds hot", 1'b0, ctrl.leds_on);
		check_reg(ADDR_FAULT_LO, 8'h0C);
		@(posedge ref_clk);
		hot <= 1'b0;
		cyc(8);
		chk_bit("boost warm", 1'b0, ctrl.boost_on);
		@(posedge ref_clk);
		cool <= 1'b1;
		dzone <= 1'b0;
		cyc(8);
		chk_bit("boost cooled", 1'b1, ctrl.boost_on);
		// overvoltage with open channel 3
		ovp_pulse();
		cyc(10);
		check_reg(ADDR_REGLAT_LO, 8'h08);
		check_reg(ADDR_CH_OVP_LO, 8'h08);
		chk_bit("open dropped", 1'b0, ctrl.ch_regulate[3]);
		chk_bit("others resume", 1'b1, ctrl.boost_on);
		chk_bit("flag cleared", 1'b0, fault_flag_n_oe);
		// overvoltage with channel 1 grounded in operation
		@(posedge ref_clk);
		shorted <= 10'h002;
		ovp_pulse();
		cyc(10);
		chk_bit("boost short", 1'b0, ctrl.boost_on);
		chk_bit("flag short", 1'b1, fault_flag_n_oe);
		check_reg(ADDR_FAULT_HI, 8'h04);
		check_reg(ADDR_SHORT_LO, 8'h02);
		@(posedge ref_clk);
		shorted <= '0;
		cyc(20);
		chk_bit("no restart", 1'b0, ctrl.boost_on);
		// enable toggle clears the latch
		@(posedge ref_clk);
		enable_pin <= 1'b0;
		cyc(10);
		check_reg(ADDR_FAULT_HI, 8'h00);
		@(posedge ref_clk);
		enable_pin <= 1'b1;
		cyc(10);
		chk_bit("rerun", 1'b1, ctrl.boost_on);
		// input overcurrent latches after the cause goes
		@(posedge ref_clk);
		oc <= 1'b1;
		cyc(4);
		@(posedge ref_clk);
		oc <= 1'b0;
		cyc(10);
		chk_bit("boost oc", 1'b0, ctrl.boost_on);
		chk_bit("leds oc", 1'b0, ctrl.leds_on);
		chk_bit("disconnect oc", 1'b0, ctrl.disconnect_on);
		chk_bit("flag oc", 1'b1, fault_flag_n_oe);
		check_reg(ADDR_FAULT_LO, 8'h01);
		@(posedge ref_clk);
		enable_pin <= 1'b0;
		cyc(10);
		chk_bit("flag freed", 1'b0, fault_flag_n_oe);
		final_report();
	end
endmodule
